// file: hw/sim_irq_masks.sv
// Stage interrupt enable masks and the active-low interrupt output.
// Assumes event inputs come from logic on clk_sys; the gpio pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none
module sim_irq_masks
  import sim_pkg::*;
#(
  parameter int unsigned STAGES = SIM_STAGES
)(
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  nrst,
  // Register access
  input  wire sim_req_s              reg_req,
  output logic [SIM_DATA_W-1:0]      reg_rdata,
  // Stage events
  input  wire logic [STAGES-1:0]     stage_upper_exceed,
  input  wire logic [STAGES-1:0]     stage_conv_done,
  input  wire logic                  gpio_pin,
  // Interrupt pin
  output logic                       irq_n
);

  sim_state_s st_q;
  sim_state_s st_d;
  logic       gpio_chg;
  logic       hit_upper;
  logic       hit_done;
  logic       hit_gpio;

  // ***************************************************************
  // Pin change detection
  // ***************************************************************
  sim_pin_watch u_pin (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .pin     (gpio_pin),
    .change  (gpio_chg)
  );

  // ***************************************************************
  // Event gating
  // ***************************************************************
  // Each event needs its own mask bit set; a zero bit blocks it fully
  assign hit_upper = |(st_q.stage_upper_limit_irq_mask_bit & stage_upper_exceed);
  assign hit_done  = |(st_q.stage_done_irq_mask_bit & stage_conv_done);
  assign hit_gpio  = st_q.gpio_change_irq_mask & gpio_chg;

  // ***************************************************************
  // Next state
  // ***************************************************************
  // Upper exceed and done each hold the pin low while they last; a pin change is a one-cycle pulse
  always_comb begin
    st_d       = st_q;
    st_d.irq_n = ~(hit_upper | hit_done | hit_gpio);
    if (reg_req.wr) begin
      if (reg_req.addr == SIM_UPPER_MASK_ADDR) begin
        // Bits 15:12 are not stored, so they always read back as zero
        st_d.stage_upper_limit_irq_mask_bit = reg_req.wdata[SIM_STAGES-1:0];
      end
      if (reg_req.addr == SIM_DONE_MASK_ADDR) begin
        st_d.stage_done_irq_mask_bit = reg_req.wdata[SIM_STAGES-1:0];
        st_d.gpio_change_irq_mask    = reg_req.wdata[SIM_GPIO_CHG_BIT];
      end
    end
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        SIM_UPPER_MASK_ADDR: begin
          st_d.rdata = {4'h0, st_q.stage_upper_limit_irq_mask_bit};
        end
        SIM_DONE_MASK_ADDR: begin
          st_d.rdata = {3'h0, st_q.gpio_change_irq_mask, st_q.stage_done_irq_mask_bit};
        end
        default: begin
          st_d.rdata = SIM_RDATA_RESET; // Unmapped here; the rest of the map answers elsewhere
        end
      endcase
    end
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  // Masks clear at reset so nothing interrupts before the host sets them up
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q.stage_upper_limit_irq_mask_bit <= SIM_MASK_RESET;
      st_q.stage_done_irq_mask_bit        <= SIM_MASK_RESET;
      st_q.gpio_change_irq_mask           <= 1'b0;
      st_q.rdata                          <= SIM_RDATA_RESET;
      st_q.irq_n                          <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign irq_n     = st_q.irq_n;

  // ***************************************************************
  // Checks
  // ***************************************************************
  // An enabled exceed pulls the pin low on the next edge
  a_upper_irq_fires: assert property (@(posedge clk_sys) disable iff (!nrst)
    (|(st_q.stage_upper_limit_irq_mask_bit & stage_upper_exceed)) |=> !irq_n)
    else $error("enabled upper exceed did not assert interrupt");

  // An enabled completion pulls the pin low on the next edge
  a_done_irq_fires: assert property (@(posedge clk_sys) disable iff (!nrst)
    (|(st_q.stage_done_irq_mask_bit & stage_conv_done)) |=> !irq_n)
    else $error("enabled completion did not assert interrupt");

  // With no enabled event pending the pin is released, whatever the raw events do
  a_masked_stays_quiet: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!(|(st_q.stage_upper_limit_irq_mask_bit & stage_upper_exceed))
     && !(|(st_q.stage_done_irq_mask_bit & stage_conv_done))
     && !(st_q.gpio_change_irq_mask && gpio_chg)) |=> irq_n)
    else $error("interrupt asserted with no enabled event");

  // The upper bank takes the low twelve bits of a write
  a_upper_mask_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    (reg_req.wr && reg_req.addr == SIM_UPPER_MASK_ADDR) |=>
      st_q.stage_upper_limit_irq_mask_bit == $past(reg_req.wdata[SIM_STAGES-1:0]))
    else $error("upper mask write not stored");

  // Back-to-back write then read of the done bank returns the written word
  a_done_mask_readback: assert property (@(posedge clk_sys) disable iff (!nrst)
    (reg_req.wr && reg_req.addr == SIM_DONE_MASK_ADDR && !reg_req.rd)
      ##1 (reg_req.rd && reg_req.addr == SIM_DONE_MASK_ADDR && !reg_req.wr) |=>
      reg_rdata == {3'h0, $past(reg_req.wdata[SIM_GPIO_CHG_BIT:0], 2)})
    else $error("done mask readback mismatch");

  // An enabled pin change gives a low cycle on the pin
  a_gpio_change_irq: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_q.gpio_change_irq_mask && gpio_chg) |=> !irq_n)
    else $error("pin change did not assert interrupt");

  // Bits above the last stage are not stored and read back as zero
  a_upper_read_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    (reg_req.rd && reg_req.addr == SIM_UPPER_MASK_ADDR) |=> reg_rdata[15:12] == 4'h0)
    else $error("unused upper bits not zero");

  // The pin goes low only for an enabled event seen on the edge before
  a_irq_needs_event: assert property (@(posedge clk_sys) disable iff (!nrst)
    !irq_n |-> $past(hit_upper || hit_done || hit_gpio))
    else $error("interrupt low with no enabled event");

  // A pin change with its enable clear and nothing else pending leaves the pin high
  a_gpio_masked_quiet: assert property (@(posedge clk_sys) disable iff (!nrst)
    (gpio_chg && !st_q.gpio_change_irq_mask && !hit_upper && !hit_done) |=> irq_n)
    else $error("masked pin change asserted interrupt");

  // ***************************************************************
  // Register and reset checks
  // ***************************************************************
  // These watch the register port and the stored banks, plus the pin at reset.
  // A read answers on the next edge from the banks as they stood before it,
  // so a read beside a write to the same place sees the old word.

  // Reset leaves every mask clear, the pin released and the read word zero
  a_reset_clears_state: assert property (@(posedge clk_sys)
    !nrst |=> (st_q.stage_upper_limit_irq_mask_bit == SIM_MASK_RESET)
      && (st_q.stage_done_irq_mask_bit == SIM_MASK_RESET)
      && !st_q.gpio_change_irq_mask
      && irq_n
      && (reg_rdata == SIM_RDATA_RESET))
    else $error("state not cleared by reset");

  // The read word stands until the next read strobe, so a slow host can fetch it late
  a_rdata_holds: assert property (@(posedge clk_sys) disable iff (!nrst)
    !reg_req.rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  // Places outside the two masks answer zero
  a_unmapped_read_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    (reg_req.rd && reg_req.addr != SIM_UPPER_MASK_ADDR && reg_req.addr != SIM_DONE_MASK_ADDR)
      |=> reg_rdata == SIM_RDATA_RESET)
    else $error("unmapped read not zero");

  // An upper bank read returns the stored stage bits
  a_upper_read_value: assert property (@(posedge clk_sys) disable iff (!nrst)
    (reg_req.rd && reg_req.addr == SIM_UPPER_MASK_ADDR) |=>
      reg_rdata[SIM_STAGES-1:0] == $past(st_q.stage_upper_limit_irq_mask_bit))
    else $error("upper mask read not as stored");

  // A done bank read returns the stage bits and the pin change enable
  a_done_read_value: assert property (@(posedge clk_sys) disable iff (!nrst)
    (reg_req.rd && reg_req.addr == SIM_DONE_MASK_ADDR) |=>
      reg_rdata == {3'h0, $past(st_q.gpio_change_irq_mask), $past(st_q.stage_done_irq_mask_bit)})
    else $error("done mask read not as stored");

  // Stage bits of the done bank take the written word
  a_done_mask_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    (reg_req.wr && reg_req.addr == SIM_DONE_MASK_ADDR) |=>
      st_q.stage_done_irq_mask_bit == $past(reg_req.wdata[SIM_STAGES-1:0]))
    else $error("done mask write not stored");

  // The pin change enable sits beside the done bits
  a_gpio_mask_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    (reg_req.wr && reg_req.addr == SIM_DONE_MASK_ADDR) |=>
      st_q.gpio_change_irq_mask == $past(reg_req.wdata[SIM_GPIO_CHG_BIT]))
    else $error("pin change enable write not stored");

  // A write to the upper bank leaves the done bank and pin enable alone
  a_upper_write_isolated: assert property (@(posedge clk_sys) disable iff (!nrst)
    (reg_req.wr && reg_req.addr == SIM_UPPER_MASK_ADDR) |=>
      ($stable(st_q.stage_done_irq_mask_bit) && $stable(st_q.gpio_change_irq_mask)))
    else $error("upper write disturbed done bank");

  // A write to the done bank leaves the upper bank alone
  a_done_write_isolated: assert property (@(posedge clk_sys) disable iff (!nrst)
    (reg_req.wr && reg_req.addr == SIM_DONE_MASK_ADDR) |=>
      $stable(st_q.stage_upper_limit_irq_mask_bit))
    else $error("done write disturbed upper bank");

  // Idle cycles and writes elsewhere in the map leave every mask as it was
  a_masks_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    !(reg_req.wr && (reg_req.addr == SIM_UPPER_MASK_ADDR || reg_req.addr == SIM_DONE_MASK_ADDR)) |=>
      ($stable(st_q.stage_upper_limit_irq_mask_bit) && $stable(st_q.stage_done_irq_mask_bit)
       && $stable(st_q.gpio_change_irq_mask)))
    else $error("mask changed without a write");

endmodule
`default_nettype wire

// file: hw/sim_pkg.sv
// Constants, field layout and carrier types for the stage interrupt enable masks.
// Assumes a register port on the device clock, fed by the serial interface logic.
package sim_pkg;

  // ***************************************************************
  // Sizes and addresses
  // ***************************************************************
  localparam int unsigned SIM_ADDR_W   = 10;
  localparam int unsigned SIM_DATA_W   = 16;
  localparam int unsigned SIM_STAGES   = 12;
  localparam logic [SIM_ADDR_W-1:0] SIM_UPPER_MASK_ADDR = 10'h006;
  localparam logic [SIM_ADDR_W-1:0] SIM_DONE_MASK_ADDR  = 10'h007;

  // ***************************************************************
  // Field positions and reset values
  // ***************************************************************
  localparam int unsigned SIM_GPIO_CHG_BIT = 12;
  localparam logic [SIM_STAGES-1:0] SIM_MASK_RESET = 12'h000;
  localparam logic [SIM_DATA_W-1:0] SIM_RDATA_RESET = 16'h0000;

  // Register access request from the serial interface
  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [SIM_ADDR_W-1:0] addr;
    logic [SIM_DATA_W-1:0] wdata;
  } sim_req_s;

  // Pin watcher state
  typedef struct packed {
    logic meta;
    logic sync;
    logic       last;
    logic       chg;
    logic [2:0] fill;
  } sim_pin_s;

  // Whole state of the mask block
  typedef struct packed {
    logic [SIM_STAGES-1:0] stage_upper_limit_irq_mask_bit;
    logic [SIM_STAGES-1:0] stage_done_irq_mask_bit;
    logic                  gpio_change_irq_mask;
    logic [SIM_DATA_W-1:0] rdata;
    logic                  irq_n;
  } sim_state_s;

endpackage

// file: hw/sim_pin_watch.sv
// Synchroniser and level-change detector for the general-purpose input pin.
// Assumes the pin is asynchronous to clk_sys; changes shorter than two cycles may be missed.
`timescale 1ns/1ps
`default_nettype none
module sim_pin_watch
  import sim_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // Pin and result
  input  wire logic pin,
  output logic      change
);

  sim_pin_s st_q;
  sim_pin_s st_d;

  // ***************************************************************
  // Next state
  // ***************************************************************
  // Only the second and third stages feed the comparison, the first may be metastable
  always_comb begin
    st_d      = st_q;
    st_d.meta = pin;
    st_d.sync = st_q.meta;
    st_d.last = st_q.sync;
    st_d.fill = {st_q.fill[1:0], 1'b1};
    // Held off until last holds a real sample, so a pin idling high gives no edge after reset
    st_d.chg  = (st_q.sync ^ st_q.last) & st_q.fill[2];
  end

  // Clears to all zero; the fill bits keep change low until the chain holds real samples
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign change = st_q.chg;

endmodule
`default_nettype wire

// file: verification/sim_host_model.sv
// Host processor model driving the register strobe port of the mask block.
// Assumes the block takes a request on the rising edge and answers reads one edge later.
`timescale 1ns/1ps
`default_nettype none
module sim_host_model
  import sim_pkg::*;
(
  // Clock
  input  wire logic                  clk_sys,
  // Register port
  output var sim_req_s               req,
  input  wire logic [SIM_DATA_W-1:0] rdata
);
  initial req = '0;
  // One-cycle write; released lines flip so a stale word never looks valid
  task automatic wr(input logic [SIM_ADDR_W-1:0] a, input logic [SIM_DATA_W-1:0] d);
    @(posedge clk_sys);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // One-cycle read, sampled once the registered answer has landed
  task automatic rd(input logic [SIM_ADDR_W-1:0] a, output logic [SIM_DATA_W-1:0] d);
    @(posedge clk_sys);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~req.wdata};
    @(posedge clk_sys);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~req.wdata};
    @(posedge clk_sys);
    #1 d = rdata;
  endtask
  // Write, then read the same place on the very next cycle; the read sees the new word
  task automatic wr_rd(input logic [SIM_ADDR_W-1:0] a, input logic [SIM_DATA_W-1:0] dw,
                       output logic [SIM_DATA_W-1:0] d);
    @(posedge clk_sys);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: dw};
    @(posedge clk_sys);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~dw};
    @(posedge clk_sys);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: dw};
    @(posedge clk_sys);
    #1 d = rdata;
  endtask
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the stage interrupt masks, random events plus corner cases.
// Assumes the host model in sim_host_model and the package sim_pkg.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import sim_pkg::*;
;
  logic            clk_sys = 0, nrst = 0, gpio_pin = 0, chk_en = 0, exp_n = 1, irq_n;
  logic [11:0]     ex = '0, dn = '0, um = '0;
  logic [12:0]     dm = '0;
  logic [15:0]     s = 16'h003c, d, rdata;
  sim_req_s        req;
  int              failures = 0, total_checks = 0, n;

  sim_irq_masks u_sim_irq_masks (.clk_sys(clk_sys), .nrst(nrst), .reg_req(req), .reg_rdata(rdata),
    .stage_upper_exceed(ex), .stage_conv_done(dn), .gpio_pin(gpio_pin), .irq_n(irq_n));
  sim_host_model u_sim_host_model (.clk_sys(clk_sys), .req(req), .rdata(rdata));

  // Fixed-seed random source
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Readback: unused bits drop, unmapped places answer zero
  function automatic logic [15:0] reg_exp(input logic [9:0] a, input logic [15:0] v);
    return (a == 10'h006) ? (v & 16'h0fff) : (a == 10'h007) ? (v & 16'h1fff) : 16'h0000;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    total_checks++;
    if (seen !== expv) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic end_sim;
    if (failures == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always #25 clk_sys = ~clk_sys;
  // Reference interrupt, one cycle behind the enabled events that cause it
  always @(posedge clk_sys) begin
    if (chk_en) check({15'h0, irq_n}, {15'h0, exp_n});
    exp_n = !(|(ex & um) || |(dn & dm[11:0]));
    if (req.wr && req.addr == 10'h006) um = req.wdata[11:0];
    if (req.wr && req.addr == 10'h007) dm = req.wdata[12:0];
  end

  // Watchdog at 20000 cycles, far beyond the roughly 1200 cycles at most the run needs
  initial begin
    #(50 * 20000);
    failures++;
    end_sim();
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    // Reset values, then every bit written high and read back
    for (int a = 6; a < 10; a++) begin
      u_sim_host_model.rd(a[9:0], d);
      check(d, 16'h0000);
      u_sim_host_model.wr(a[9:0], 16'hffff);
      u_sim_host_model.rd(a[9:0], d);
      check(d, reg_exp(a[9:0], 16'hffff));
    end
    // Write and read in back-to-back cycles: the read sees the new word
    u_sim_host_model.wr_rd(SIM_DONE_MASK_ADDR, 16'h1abc, d);
    check(d, 16'h1abc);
    // Random masks against random events; done pulses kept sparse
    chk_en <= 1'b1;
    repeat (60) begin
      s = lfsr(s);
      u_sim_host_model.wr(s[0] ? 10'h006 : 10'h007, s & 16'h0fff);
      repeat (int'(s[3:0]) + 1) begin
        @(posedge clk_sys);
        s = lfsr(s);
        ex <= s[11:0];
        dn <= s[15:4] & {12{s[1]}};
      end
    end
    // All stage events firing with both masks cleared must stay silent
    u_sim_host_model.wr(10'h006, 16'h0000);
    u_sim_host_model.wr(10'h007, 16'h0000);
    ex <= 12'hfff;
    dn <= 12'hfff;
    repeat (6) @(posedge clk_sys);
    chk_en <= 1'b0;
    ex <= '0;
    dn <= '0;
    // Pin change gives one low cycle only while its enable is set
    for (int m = 0; m < 2; m++) begin
      u_sim_host_model.wr(10'h007, m ? 16'h0000 : 16'h1000);
      repeat (8) @(posedge clk_sys);
      gpio_pin <= ~gpio_pin;
      n = 0;
      repeat (10) begin
        @(posedge clk_sys);
        #1 if (irq_n === 1'b0) n++;
      end
      check(n[15:0], m ? 16'h0000 : 16'h0001);
    end
    // Mid-run reset with the pin held high: the mask clears and no false pin change follows
    gpio_pin <= 1'b1;
    u_sim_host_model.wr(10'h006, 16'h0a5a);
    u_sim_host_model.rd(10'h006, d);
    check(d, 16'h0a5a);
    nrst <= 1'b0;
    @(posedge clk_sys);
    nrst <= 1'b1;
    u_sim_host_model.wr(10'h007, 16'h1000);
    n = 0;
    repeat (10) begin
      @(posedge clk_sys);
      #1 if (irq_n === 1'b0) n++;
    end
    check(n[15:0], 16'h0000);
    u_sim_host_model.rd(10'h006, d);
    check(d, 16'h0000);
    end_sim();
  end
endmodule
`default_nettype wire
